// *** bench/beat_mem_model.sv ***
`timescale 1ns/10ps
// Memory side: answers each beat request after a set latency
module beat_mem_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic beat_req,
   input wire logic stall,
   input wire logic [1:0] lat,
   output logic beat_done
);
   logic [1:0] wait_q;
   always_ff @(posedge core_clk) begin
      if (!rstn || !beat_req || stall) begin
         wait_q <= 2'h0;
         beat_done <= 1'b0;
      end else if (wait_q >= lat && !beat_done) begin
         wait_q <= 2'h0;
         beat_done <= 1'b1;
      end else begin
         wait_q <= wait_q + 2'h1;
         beat_done <= 1'b0;
      end
   end
endmodule

// *** bench/dma_blk_ctrl_tb.sv ***
`timescale 1ns/10ps
module dma_blk_ctrl_tb;
   logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic standby_sleep, beat_done, awready, wready, bvalid, arready;
   logic rvalid, beat_req, chan_event, irq, ram_access_ok, stall, oe, mk, ce;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, base;
   logic [3:0] wstrb;
   logic [2:0] evs;
   logic [1:0] bresp, rresp, ram_back_bias, beat_size, lat, rs, sel, sz;
   logic [1:0] act;
   int fail_count, num_checks, ev_cnt, cnt;
   dma_blk_ctrl #(.CH_NUM(3)) dma_blk_ctrl_inst (.core_clk(core_clk),
      .rstn(rstn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .standby_sleep(standby_sleep), .ram_back_bias(ram_back_bias),
      .beat_done(beat_done), .bus_error(evs[2]), .ev_suspend(evs[0]),
      .ev_resume(evs[1]), .beat_req(beat_req), .beat_size(beat_size),
      .chan_event(chan_event), .irq(irq), .ram_access_ok(ram_access_ok));
   beat_mem_model beat_mem_model_inst (.core_clk(core_clk), .rstn(rstn),
      .beat_req(beat_req), .stall(stall), .lat(lat), .beat_done(beat_done));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) if (chan_event === 1'b1) ev_cnt++;
   task automatic test_done;
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic guard(input bit late);
      if (late) begin
         fail_count++;
         $display("Error at %0t: wait ran out", $time);
         test_done();
      end
   endtask
   task automatic axw(input logic [5:0] i, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr <= {i, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(negedge core_clk); n++; end
      while ((awready & wready) !== 1'b1 && n < 60);
      @(posedge core_clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(negedge core_clk); n++; end while (bvalid !== 1'b1 && n < 60);
      rs = bresp;
      @(posedge core_clk);
      bready <= 1'b0;
      guard(n >= 60);
   endtask
   task automatic axr(input logic [5:0] i);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(negedge core_clk); n++; end while (arready !== 1'b1 && n < 60);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do begin @(negedge core_clk); n++; end while (rvalid !== 1'b1 && n < 60);
      rd = rdata;
      rs = rresp;
      @(posedge core_clk);
      rready <= 1'b0;
      guard(n >= 60);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk);
      evs <= v;
      @(posedge core_clk);
      evs <= 3'h0;
   endtask
   task automatic run_out;
      int n;
      n = 0;
      do begin @(negedge core_clk); n++; end while (beat_req === 1'b1 && n < 200);
      repeat (3) @(negedge core_clk);
      guard(n >= 200);
   endtask
   task automatic state_is(input logic [31:0] m, input logic [31:0] e);
      axr(dma_blk_pkg::IDX_CHAN_STATE);
      chk(rd & m, e);
   endtask
   function automatic int exp_ev(logic [1:0] s, logic en, int c);
      if (!en) return 0;
      if (s == dma_blk_pkg::EVO_BLOCK) return 1;
      return (s == dma_blk_pkg::EVO_BEAT) ? c : 0;
   endfunction
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, standby_sleep} = '0;
      {awaddr, araddr, wdata, evs, ram_back_bias, lat, stall} = '0;
      wstrb = 4'hF;
      ce = 1'b1;
      void'($urandom(78));
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      axr(dma_blk_pkg::IDX_STATUS);
      chk(rd, 32'h0);
      state_is(32'h003FFFCB, 32'h0);
      base = $urandom & 32'hFFFF_FFF0;
      axw(dma_blk_pkg::IDX_WB_BASE, base);
      chk(rs, dma_blk_pkg::RESP_OKAY);
      axr(dma_blk_pkg::IDX_BLOCK_BEAT_COUNT_ADDR);
      chk(rd, base + 3 * dma_blk_pkg::DESC_STRIDE + dma_blk_pkg::BLOCK_BEAT_COUNT_OFS);
      axw(6'h0B, $urandom);
      chk(rs, dma_blk_pkg::RESP_SLVERR);
      axr(6'h0B);
      chk(rd, 32'h0);
      chk(rs, dma_blk_pkg::RESP_SLVERR);
      for (int a = 0; a < 4; a++) for (int e = 0; e < 4; e++) begin
         act = a[1:0];
         sel = e[1:0];
         cnt = 1 + $urandom % 4;
         oe = $urandom % 2;
         mk = $urandom % 2;
         sz = $urandom % 3;
         lat <= $urandom % 4;
         axw(dma_blk_pkg::IDX_BEAT_COUNT, cnt);
         axw(dma_blk_pkg::IDX_CHANNEL_CONTROL, {30'h0, oe, 1'b0});
         axw(dma_blk_pkg::IDX_MASK, {31'h0, mk});
         axw(dma_blk_pkg::IDX_BLOCK_CONTROL,
            {21'h0, 1'b1, sz, 3'h0, act, sel, 1'b1});
         chk(beat_size, sz);
         ev_cnt = 0;
         axw(dma_blk_pkg::IDX_COMMAND, 32'h1);
         run_out;
         chk(ev_cnt, exp_ev(sel, oe, cnt));
         chk(irq, act[0] & mk);
         state_is(32'h003FFFDB, {27'h0, 1'b1, 2'h0, act[1], 1'b0});
         axr(dma_blk_pkg::IDX_STATUS);
         chk(rd[2:0], {act[1], 1'b0, act[0]});
         chk(irq, 1'b0);
         axw(dma_blk_pkg::IDX_COMMAND, 32'h8);
      end
      axw(dma_blk_pkg::IDX_BEAT_COUNT, 32'h2);
      axw(dma_blk_pkg::IDX_BLOCK_CONTROL, 32'h400);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h1);
      state_is(32'h3, 32'h2);
      axr(dma_blk_pkg::IDX_STATUS);
      chk(rd[2], 1'b1);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h8);
      stall <= 1'b1;
      axw(dma_blk_pkg::IDX_CHANNEL_CONTROL, 32'h0);
      axw(dma_blk_pkg::IDX_BEAT_COUNT, 32'h3);
      axw(dma_blk_pkg::IDX_BLOCK_CONTROL, 32'h401);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h1);
      chk(beat_req, 1'b1);
      state_is(32'h003FFFC0, 32'h3 << 6);
      ce <= 1'b0;
      stall <= 1'b0;
      repeat (6) @(posedge core_clk);
      stall <= 1'b1;
      @(posedge core_clk);
      ce <= 1'b1;
      state_is(32'h003FFFC0, 32'h3 << 6);
      standby_sleep <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         @(posedge core_clk);
         ram_back_bias <= b[1:0];
         @(negedge core_clk);
         chk(ram_access_ok, b == 0);
         chk(beat_req, 1'b0);
      end
      ram_back_bias <= 2'h0;
      axw(dma_blk_pkg::IDX_CHANNEL_CONTROL, 32'h1);
      chk(beat_req, 1'b1);
      standby_sleep <= 1'b0;
      axw(dma_blk_pkg::IDX_CHANNEL_CONTROL, 32'h0);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h2);
      state_is(32'h3, 32'h2);
      standby_sleep <= 1'b1;
      repeat (4) @(posedge core_clk);
      standby_sleep <= 1'b0;
      axw(dma_blk_pkg::IDX_COMMAND, 32'h4);
      state_is(32'h3, 32'h1);
      pulse(3'h1);
      state_is(32'h3, 32'h1);
      axw(dma_blk_pkg::IDX_CHANNEL_CONTROL, 32'h4);
      pulse(3'h1);
      state_is(32'h3, 32'h2);
      pulse(3'h2);
      state_is(32'h3, 32'h1);
      pulse(3'h4);
      state_is(32'hB, 32'h0);
      axr(dma_blk_pkg::IDX_STATUS);
      chk(rd[1], 1'b1);
      axw(dma_blk_pkg::IDX_BLOCK_CONTROL, 32'h401);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h1);
      state_is(32'hB, 32'h9);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h8);
      state_is(32'hB, 32'h0);
      axw(dma_blk_pkg::IDX_BLOCK_CONTROL, 32'h701);
      axw(dma_blk_pkg::IDX_COMMAND, 32'h1);
      state_is(32'hB, 32'h0);
      axr(dma_blk_pkg::IDX_STATUS);
      chk(rd[1], 1'b1);
      test_done();
   end
endmodule

// *** verilog/dma_blk_ctrl.sv ***
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dma_blk_ctrl #(
   parameter int CH_NUM = 0
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic standby_sleep,
   input wire logic [1:0] ram_back_bias,
   input wire logic beat_done,
   input wire logic bus_error,
   input wire logic ev_suspend,
   input wire logic ev_resume,
   output logic beat_req,
   output logic [1:0] beat_size,
   output logic chan_event,
   output logic irq,
   output logic ram_access_ok
);
   if (CH_NUM < 0 || CH_NUM > 15) begin : g_bad_ch
      $error("CH_NUM out of range");
   end

   typedef struct packed {
      dma_blk_pkg::chan_state_e state;
      logic [15:0] cnt;
      logic wb_valid;
      logic [dma_blk_pkg::BCTRL_W-1:0] bctrl;
      logic [15:0] block_beat_count;
      logic [dma_blk_pkg::CTL_W-1:0] chctl;
      logic [dma_blk_pkg::STAT_W-1:0] status;
      logic [dma_blk_pkg::STAT_W-1:0] mask;
      logic [31:0] wb_base;
      logic evo;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } regs_s;

   regs_s q;
   regs_s d;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic wr;
   logic rd;
   logic [5:0] widx;
   logic [5:0] ridx;
   logic [3:0] cmd;
   logic ev_susp_ok;
   logic ev_res_ok;
   logic ram_ok;
   logic can_run;
   logic beat_ok;
   logic blk_done;
   logic err_ev;
   logic fetch;
   logic [1:0] act;
   logic [1:0] event_output_select;
   logic [dma_blk_pkg::STAT_W-1:0] set_st;
   logic [31:0] block_beat_count_addr;
   logic [31:0] wm;

   localparam int BEATSZ_HI = dma_blk_pkg::BEATSZ_LSB + 1;
   localparam logic [31:0] DESC_OFS = 32'(CH_NUM) * dma_blk_pkg::DESC_STRIDE;

   assign wr = ce && awvalid && wvalid && !q.bvalid;
   assign rd = ce && arvalid && !q.rvalid;
   assign awready = wr;
   assign wready = wr;
   assign arready = rd;
   assign widx = awaddr[7:2];
   assign ridx = araddr[7:2];
   assign act = q.bctrl[dma_blk_pkg::BLKACT_LSB +: 2];
   assign event_output_select = q.bctrl[dma_blk_pkg::EVENT_OUTPUT_SELECT_LSB +: 2];
   assign block_beat_count_addr = q.wb_base + DESC_OFS + dma_blk_pkg::BLOCK_BEAT_COUNT_OFS;

   assign ev_susp_ok = ev_suspend && q.chctl[dma_blk_pkg::EVENT_INPUT_ENABLE_BIT];
   assign ev_res_ok = ev_resume && q.chctl[dma_blk_pkg::EVENT_INPUT_ENABLE_BIT];
   assign ram_ok = !standby_sleep
      || ram_back_bias == dma_blk_pkg::BBIAS_OK;
   assign can_run = q.state == dma_blk_pkg::CH_ACTIVE && ram_ok
      && (q.chctl[dma_blk_pkg::RUN_IN_STANDBY_BIT] || !standby_sleep);
   assign beat_ok = can_run && beat_done && q.cnt != 16'h0000;
   assign blk_done = can_run
      && (q.cnt == 16'h0000 || (beat_done && q.cnt == 16'h0001));
   assign err_ev = q.state == dma_blk_pkg::CH_ACTIVE && bus_error;

   always_comb begin
      d = q;
      fetch = 1'b0;
      set_st = '0;
      cmd = '0;
      wm = merge(32'h0000_0000, wdata, wstrb);
      if (wr && widx == dma_blk_pkg::IDX_COMMAND) begin
         cmd = wm[3:0];
      end
      // Beat and block progress
      if (beat_ok) begin
         d.cnt = q.cnt - 16'h0001;
      end
      d.evo = q.chctl[dma_blk_pkg::EVENT_OUTPUT_ENABLE_BIT]
         && ((event_output_select == dma_blk_pkg::EVO_BEAT && beat_ok)
         || (event_output_select == dma_blk_pkg::EVO_BLOCK && blk_done));
      if (blk_done) begin
         d.wb_valid = 1'b0;
         if (act[dma_blk_pkg::ACT_IRQ_BIT]) begin
            set_st[dma_blk_pkg::ST_BLOCK] = 1'b1;
         end
         if (act[dma_blk_pkg::ACT_SUSP_BIT]) begin
            d.state = dma_blk_pkg::CH_SUSP;
            set_st[dma_blk_pkg::ST_SUSP] = 1'b1;
         end else if (q.bctrl[dma_blk_pkg::LAST_BIT]) begin
            d.state = dma_blk_pkg::CH_IDLE;
         end else begin
            fetch = 1'b1;
         end
      end
      // Commands and enabled input events
      if (cmd[dma_blk_pkg::CMD_START]
         && q.state == dma_blk_pkg::CH_IDLE) begin
         fetch = 1'b1;
      end
      if ((cmd[dma_blk_pkg::CMD_SUSPEND] || ev_susp_ok)
         && q.state == dma_blk_pkg::CH_ACTIVE && !blk_done) begin
         d.state = dma_blk_pkg::CH_SUSP;
         set_st[dma_blk_pkg::ST_SUSP] = 1'b1;
      end
      if ((cmd[dma_blk_pkg::CMD_RESUME] || ev_res_ok)
         && q.state == dma_blk_pkg::CH_SUSP) begin
         if (q.wb_valid) begin
            d.state = dma_blk_pkg::CH_ACTIVE;
         end else begin
            fetch = 1'b1;
         end
      end
      if (fetch) begin
         d.cnt = q.block_beat_count;
         d.wb_valid = q.bctrl[dma_blk_pkg::VALID_BIT];
         if (!q.bctrl[dma_blk_pkg::VALID_BIT]) begin
            d.state = dma_blk_pkg::CH_SUSP;
            set_st[dma_blk_pkg::ST_SUSP] = 1'b1;
         end else if (q.bctrl[BEATSZ_HI:dma_blk_pkg::BEATSZ_LSB] == 2'h3) begin
            d.state = dma_blk_pkg::CH_IDLE;
            d.wb_valid = 1'b0;
            set_st[dma_blk_pkg::ST_ERROR] = 1'b1;
         end else begin
            d.state = dma_blk_pkg::CH_ACTIVE;
         end
      end
      if (err_ev || cmd[dma_blk_pkg::CMD_ABORT]) begin
         d.state = dma_blk_pkg::CH_IDLE;
         d.wb_valid = 1'b0;
         set_st[dma_blk_pkg::ST_ERROR] = err_ev;
         d.evo = 1'b0;
      end
      // Register writes
      if (wr) begin
         d.bvalid = 1'b1;
         d.bresp = dma_blk_pkg::RESP_OKAY;
         case (widx)
            dma_blk_pkg::IDX_BLOCK_CONTROL: begin
               wm = merge({21'h0, q.bctrl}, wdata, wstrb);
               d.bctrl = wm[dma_blk_pkg::BCTRL_W-1:0];
            end
            dma_blk_pkg::IDX_BEAT_COUNT: begin
               wm = merge({16'h0, q.block_beat_count}, wdata, wstrb);
               d.block_beat_count = wm[15:0];
            end
            dma_blk_pkg::IDX_CHANNEL_CONTROL: begin
               wm = merge({29'h0, q.chctl}, wdata, wstrb);
               d.chctl = wm[2:0];
            end
            dma_blk_pkg::IDX_MASK: begin
               wm = merge({29'h0, q.mask}, wdata, wstrb);
               d.mask = wm[2:0];
            end
            dma_blk_pkg::IDX_WB_BASE: begin
               d.wb_base = merge(q.wb_base, wdata, wstrb);
            end
            dma_blk_pkg::IDX_COMMAND, dma_blk_pkg::IDX_STATUS,
            dma_blk_pkg::IDX_BLOCK_BEAT_COUNT_ADDR, dma_blk_pkg::IDX_CHAN_STATE: begin
               d.bresp = dma_blk_pkg::RESP_OKAY;
            end
            default: begin
               d.bresp = dma_blk_pkg::RESP_SLVERR;
            end
         endcase
      end else if (q.bvalid && bready && ce) begin
         d.bvalid = 1'b0;
      end
      // Status flags: set wins over clear-on-read
      d.status = q.status | set_st;
      if (rd) begin
         d.rvalid = 1'b1;
         d.rresp = dma_blk_pkg::RESP_OKAY;
         case (ridx)
            dma_blk_pkg::IDX_BLOCK_CONTROL: d.rdata = {21'h0, q.bctrl};
            dma_blk_pkg::IDX_BEAT_COUNT: d.rdata = {16'h0, q.block_beat_count};
            dma_blk_pkg::IDX_CHANNEL_CONTROL: d.rdata = {29'h0, q.chctl};
            dma_blk_pkg::IDX_STATUS: begin
               d.rdata = {29'h0, q.status};
               d.status = set_st;
            end
            dma_blk_pkg::IDX_MASK: d.rdata = {29'h0, q.mask};
            dma_blk_pkg::IDX_COMMAND: d.rdata = 32'h0000_0000;
            dma_blk_pkg::IDX_WB_BASE: d.rdata = q.wb_base;
            dma_blk_pkg::IDX_BLOCK_BEAT_COUNT_ADDR: d.rdata = block_beat_count_addr;
            dma_blk_pkg::IDX_CHAN_STATE: begin
               d.rdata = {10'h000, q.cnt, 1'b0, ram_ok, q.wb_valid, 1'b0,
                  q.state};
            end
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = dma_blk_pkg::RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && rready && ce) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = q.rdata;
   assign beat_req = can_run && q.cnt != 16'h0000;
   assign beat_size = q.bctrl[BEATSZ_HI:dma_blk_pkg::BEATSZ_LSB];
   assign chan_event = q.evo;
   assign irq = |(q.status & q.mask);
   assign ram_access_ok = ram_ok;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_block_end;
      ce && blk_done && !err_ev && cmd == 4'h0;
   endsequence

   a_standby_gate: assert property (
      standby_sleep && !q.chctl[dma_blk_pkg::RUN_IN_STANDBY_BIT] |-> !beat_req)
      else $error("beat request in standby without run bit");
   a_ram_gate: assert property (
      standby_sleep && ram_back_bias != dma_blk_pkg::BBIAS_OK
      |-> !beat_req && !ram_access_ok)
      else $error("RAM reached while back biased");
   a_beat_size: assert property (
      beat_req |-> beat_size != 2'h3)
      else $error("reserved beat size in use");
   a_block_irq: assert property (
      s_block_end ##0 act[dma_blk_pkg::ACT_IRQ_BIT]
      && q.mask[dma_blk_pkg::ST_BLOCK] && !rd |=> irq)
      else $error("block interrupt missing");
   a_block_susp: assert property (
      s_block_end ##0 act[dma_blk_pkg::ACT_SUSP_BIT]
      |=> q.state == dma_blk_pkg::CH_SUSP)
      else $error("block suspend action not taken");
   a_beat_event: assert property (
      ce && beat_ok && event_output_select == dma_blk_pkg::EVO_BEAT && !err_ev
      && cmd == 4'h0 && q.chctl[dma_blk_pkg::EVENT_OUTPUT_ENABLE_BIT] |=> chan_event)
      else $error("beat event strobe missing");
   a_event_off: assert property (
      ce && !q.chctl[dma_blk_pkg::EVENT_OUTPUT_ENABLE_BIT] |=> !chan_event)
      else $error("event issued while output disabled");
   a_invalid_susp: assert property (
      ce && fetch && !q.bctrl[dma_blk_pkg::VALID_BIT] && !err_ev
      && !cmd[dma_blk_pkg::CMD_ABORT] |=> q.state == dma_blk_pkg::CH_SUSP)
      else $error("invalid descriptor not suspended");
   a_wb_clear: assert property (
      ce && (blk_done || err_ev) && !fetch |=> !q.wb_valid)
      else $error("write-back valid not cleared");
   a_count_step: assert property (
      ce && beat_ok && !fetch |=> q.cnt == $past(q.cnt) - 16'h0001)
      else $error("beat count not decremented");
endmodule

// *** verilog/dma_blk_pkg.sv ***
// Behaviour
// - Standby transfers only when run-in-standby set
// - Interrupt wakes device; events usable during sleep
// - Standby RAM access only with back-bias 0x0
// - Beat size 0/1/2 gives 8/16/32 bits
// - Action 0/1 disables after last block; 1 interrupts
// - Action 2 suspends; 3 suspends and interrupts
// - Event select: none, per block, per beat
// - Invalid descriptor fetched suspends the channel
// - Abort, error or completion clears write-back valid
// - Beat count at base+channel*0x10+0x02
// - Output event only with output enable set
// - Input events act only with input enable
package dma_blk_pkg;
   localparam int ADDR_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_BLOCK_CONTROL = 6'h00;
   localparam logic [5:0] IDX_BEAT_COUNT = 6'h02;
   localparam logic [5:0] IDX_CHANNEL_CONTROL = 6'h04;
   localparam logic [5:0] IDX_STATUS = 6'h05;
   localparam logic [5:0] IDX_MASK = 6'h06;
   localparam logic [5:0] IDX_COMMAND = 6'h07;
   localparam logic [5:0] IDX_WB_BASE = 6'h08;
   localparam logic [5:0] IDX_BLOCK_BEAT_COUNT_ADDR = 6'h09;
   localparam logic [5:0] IDX_CHAN_STATE = 6'h0A;
   // Block control fields
   localparam int BCTRL_W = 11;
   localparam int VALID_BIT = 0;
   localparam int EVENT_OUTPUT_SELECT_LSB = 1;
   localparam int BLKACT_LSB = 3;
   localparam int BEATSZ_LSB = 8;
   localparam int LAST_BIT = 10;
   localparam logic [1:0] EVO_NONE = 2'h0;
   localparam logic [1:0] EVO_BLOCK = 2'h1;
   localparam logic [1:0] EVO_BEAT = 2'h3;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam int ACT_IRQ_BIT = 0;
   localparam int ACT_SUSP_BIT = 1;
   // Channel control, command and status bits
   localparam int CTL_W = 3;
   localparam int RUN_IN_STANDBY_BIT = 0;
   localparam int EVENT_OUTPUT_ENABLE_BIT = 1;
   localparam int EVENT_INPUT_ENABLE_BIT = 2;
   localparam int CMD_START = 0;
   localparam int CMD_SUSPEND = 1;
   localparam int CMD_RESUME = 2;
   localparam int CMD_ABORT = 3;
   localparam int STAT_W = 3;
   localparam int ST_BLOCK = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_SUSP = 2;
   localparam logic [1:0] BBIAS_OK = 2'h0;
   localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
   localparam logic [31:0] BLOCK_BEAT_COUNT_OFS = 32'h0000_0002;
   localparam logic [31:0] WB_BASE_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_ACTIVE = 2'b01,
      CH_SUSP = 2'b10
   } chan_state_e;
endpackage
